/* File: ptc_pkg.sv */
// Constants, register map and divide table of the periodic tick counter.
// Assumes a 32-bit APB master on pclk; no other surroundings.
`default_nettype none

package ptc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PTC_CTRL_OFFSET    = 12'h000;
  localparam logic [11:0] PTC_COUNT_OFFSET   = 12'h004;
  localparam logic [11:0] PTC_COMPARE_OFFSET = 12'h008;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int PTC_FLAG_BIT   = 7;
  localparam int PTC_CLKSEL_LSB = 5;
  localparam int PTC_IE_BIT     = 4;
  localparam int PTC_PS_LSB     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PTC_COMPARE_RST = 8'h00;
  localparam logic [7:0]  PTC_COUNT_RST   = 8'h00;
  localparam logic [1:0]  PTC_CLKSEL_RST  = 2'h0;
  localparam logic [3:0]  PTC_PS_RST      = 4'h0;
  localparam logic [17:0] PTC_PRESC_RST   = 18'h00000;

  // ----------------------------------------------------------------
  // Clock sources and divide ratios in source cycles
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTC_SRC_LPO = 2'b00,
    PTC_SRC_EXT = 2'b01,
    PTC_SRC_INT = 2'b10
  } ptc_src_t;

  localparam logic [17:0] PTC_DIV_LO [16] = '{
    18'h00001, 18'h00008, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400,
    18'h00001, 18'h00002, 18'h00004, 18'h0000A, 18'h00010, 18'h00064, 18'h001F4, 18'h003E8};
  localparam logic [17:0] PTC_DIV_HI [16] = '{
    18'h00001, 18'h00400, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000,
    18'h003E8, 18'h007D0, 18'h01388, 18'h02710, 18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40};

endpackage : ptc_pkg

`default_nettype wire

/* File: ptc_tick_counter.sv */
// Periodic tick counter: APB register slave, source select, prescaler, 8-bit modulo counter.
// Assumes source clocks are slower than pclk/2 and asynchronous to it.
//
// Functional notes
// - Count equal compare: wrap to zero, set flag
// - Compare zero flags every prescaler output edge
// - Compare write clears prescaler and counter
// - Reset loads compare value with zero
// - Reset: counter zero, prescaler off, LOW_POWER_OSC_CLOCK selected
// - Select zero stops prescaler; nonzero runs it
// - Software picks one of three sources
// - Changed source select clears prescaler, counter
// - Changed prescale select clears prescaler, counter
// - Ratio from prescale select and source bit0
// - Count per prescaler period, wrap, continue
// - Flag sets on compare-to-zero transition
// - Enabled flag requests an interrupt
// - Writing one clears flag; zero ignored
// - Eight-bit counter with eight-bit compare
// - Source codes: 00 LOW_POWER_OSC_CLOCK, 01 external, 1x internal
// - Table of ratios with source bit0 clear
// - Table of ratios with source bit0 set
// - Count readable, count writes ignored
//
// Local design decisions: the APB register port and the placing of the registers.
`default_nettype none

module ptc_tick_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        low_power_osc_clock,
  input  wire logic        external_ref_clock,
  input  wire logic        internal_ref_clock,
  output logic             tick_irq
);
  import ptc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  src_prev;
    logic [17:0] presc;
    logic [7:0]  tick_count;
    logic [7:0]  tick_compare_value;
    logic        tick_flag;
    logic        tick_irq_enable;
    logic [1:0]  tick_clock_select;
    logic [3:0]  prescale_select;
    logic [31:0] rdata;
    logic        slverr;
  } ptc_state_t;

  ptc_state_t state;
  ptc_state_t next_state;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [17:0] ptc_ratio(input logic [3:0] ps, input logic cs0);
    logic [17:0] r;
    r = 18'h00001;
    if (cs0)
    begin
      r = PTC_DIV_HI[ps];
    end
    else
    begin
      r = PTC_DIV_LO[ps];
    end
    return r;
  endfunction : ptc_ratio

  function automatic logic ptc_pick(input logic [2:0] v, input logic [1:0] sel);
    logic b;
    b = 1'b0;
    if (sel[1])
    begin
      b = v[2];
    end
    else if (sel[0])
    begin
      b = v[1];
    end
    else
    begin
      b = v[0];
    end
    return b;
  endfunction : ptc_pick

  function automatic logic [7:0] ptc_ctrl_byte(input ptc_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[PTC_FLAG_BIT] = s.tick_flag;
    b[PTC_CLKSEL_LSB +: 2] = s.tick_clock_select;
    b[PTC_IE_BIT] = s.tick_irq_enable;
    b[PTC_PS_LSB +: 4] = s.prescale_select;
    return b;
  endfunction : ptc_ctrl_byte

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        setup_phase;
  logic        wr_access;
  logic        hit_ctrl;
  logic        hit_count;
  logic        hit_compare;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_compare;
  logic [7:0]  wbyte;
  logic [17:0] ratio;
  logic        src_edge;
  logic        presc_out;
  logic        restart;
  logic        match;

  always_comb
  begin
    hit_ctrl    = 1'b0;
    hit_count   = 1'b0;
    hit_compare = 1'b0;
    if (paddr == PTC_CTRL_OFFSET)
    begin
      hit_ctrl = 1'b1;
    end
    else if (paddr == PTC_COUNT_OFFSET)
    begin
      hit_count = 1'b1;
    end
    else if (paddr == PTC_COMPARE_OFFSET)
    begin
      hit_compare = 1'b1;
    end
  end

  assign mapped      = hit_ctrl | hit_count | hit_compare;
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & mapped;
  // Only byte lane 0 carries register bits
  assign wr_ctrl     = wr_access & hit_ctrl & pstrb[0];
  assign wr_compare  = wr_access & hit_compare & pstrb[0];
  assign wbyte       = pwdata[7:0];

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  assign ratio     = ptc_ratio(state.prescale_select, state.tick_clock_select[0]);
  // Edge detect works on the second sync stage only
  assign src_edge  = ptc_pick(state.sync2 & ~state.src_prev, state.tick_clock_select);
  assign presc_out = (state.prescale_select != PTC_PS_RST) & src_edge
                     & (state.presc == ratio - 18'h00001);
  assign match     = state.tick_count == state.tick_compare_value;
  assign restart   = wr_compare
                     | (wr_ctrl & (wbyte[PTC_CLKSEL_LSB +: 2] != state.tick_clock_select))
                     | (wr_ctrl & (wbyte[PTC_PS_LSB +: 4] != state.prescale_select));

  always_comb
  begin
    next_state = state;
    next_state.sync1    = {internal_ref_clock, external_ref_clock, low_power_osc_clock};
    next_state.sync2    = state.sync1;
    next_state.src_prev = state.sync2;

    // Prescaler advances on source rising edges while running
    if (state.prescale_select == PTC_PS_RST)
    begin
      next_state.presc = PTC_PRESC_RST;
    end
    else if (src_edge)
    begin
      if (presc_out)
      begin
        next_state.presc = PTC_PRESC_RST;
      end
      else
      begin
        next_state.presc = state.presc + 18'h00001;
      end
    end

    if (presc_out)
    begin
      if (match)
      begin
        next_state.tick_count = PTC_COUNT_RST;
        next_state.tick_flag  = 1'b1;
      end
      else
      begin
        next_state.tick_count = state.tick_count + 8'h01;
      end
    end

    // ----------------------------------------------------------------
    // Register writes; count register takes none
    // ----------------------------------------------------------------
    if (wr_ctrl)
    begin
      next_state.tick_clock_select = wbyte[PTC_CLKSEL_LSB +: 2];
      next_state.tick_irq_enable   = wbyte[PTC_IE_BIT];
      next_state.prescale_select   = wbyte[PTC_PS_LSB +: 4];
      // A new tick in the same cycle wins over the clear
      if (wbyte[PTC_FLAG_BIT] & ~(presc_out & match))
      begin
        next_state.tick_flag = 1'b0;
      end
    end
    if (wr_compare)
    begin
      next_state.tick_compare_value = wbyte;
    end

    // Restart beats any count step of the same cycle
    if (restart)
    begin
      next_state.presc      = PTC_PRESC_RST;
      next_state.tick_count = PTC_COUNT_RST;
    end

    // ----------------------------------------------------------------
    // Read data captured in setup so it is stable in access
    // ----------------------------------------------------------------
    if (setup_phase)
    begin
      next_state.rdata  = 32'h00000000;
      next_state.slverr = ~mapped;
      if (hit_ctrl)
      begin
        next_state.rdata[7:0] = ptc_ctrl_byte(state);
      end
      else if (hit_count)
      begin
        next_state.rdata[7:0] = state.tick_count;
      end
      else if (hit_compare)
      begin
        next_state.rdata[7:0] = state.tick_compare_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state.sync1              <= 3'h0;
      state.sync2              <= 3'h0;
      state.src_prev           <= 3'h0;
      state.presc              <= PTC_PRESC_RST;
      state.tick_count         <= PTC_COUNT_RST;
      state.tick_compare_value <= PTC_COMPARE_RST;
      state.tick_flag          <= 1'b0;
      state.tick_irq_enable    <= 1'b0;
      state.tick_clock_select  <= PTC_CLKSEL_RST;
      state.prescale_select    <= PTC_PS_RST;
      state.rdata              <= 32'h00000000;
      state.slverr             <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states: every access ends in its first access cycle
  assign pready   = 1'b1;
  assign prdata   = state.rdata;
  assign pslverr  = state.slverr & psel & penable;
  assign tick_irq = state.tick_flag & state.tick_irq_enable;

endmodule : ptc_tick_counter

`default_nettype wire

/* File: ptc_monitor.sv */
// Checker for the tick counter's bus responses and interrupt level.
// Assumes it is bound to ptc_tick_counter and sees only its ports.
`default_nettype none

module ptc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tick_irq
);
  import ptc_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic map_hit;
  logic acc;
  logic ctl_wr;
  assign map_hit = paddr inside {PTC_CTRL_OFFSET, PTC_COUNT_OFFSET, PTC_COMPARE_OFFSET};
  assign acc     = psel && penable;
  assign ctl_wr  = acc && pwrite && pstrb[0] && paddr == PTC_CTRL_OFFSET;
  AST_READY: assert property (acc |-> pready) else $error("pready low in access");
  AST_ERR_UNMAPPED: assert property (acc && !map_hit |-> pslverr) else $error("no error on unmapped");
  AST_ERR_MAPPED: assert property (acc && map_hit |-> !pslverr) else $error("error on mapped");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("error outside access");
  AST_RD_UNMAPPED: assert property (psel && !penable && !map_hit |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HIGH: assert property (psel && !penable && !pwrite |=> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_IRQ_OFF: assert property (ctl_wr && !pwdata[PTC_IE_BIT] |=> !tick_irq)
    else $error("irq without enable");
  AST_IRQ_HOLD: assert property (tick_irq && !ctl_wr |=> tick_irq)
    else $error("irq dropped on its own");
endmodule : ptc_monitor

`default_nettype wire

/* File: tb_ptc_tick_counter.sv */
// Self-checking bench: APB master, source clock stimulus, count model.
// Assumes ptc_pkg and ptc_monitor are compiled first.
`default_nettype none

module tb_ptc_tick_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [2:0]  src_clk = 3'h0;
  logic        pready;
  logic        pslverr;
  logic        tick_irq;
  logic        err;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] v;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cnt, flag, cmpv, s, p, c, r;
  int          div [2][16] = '{'{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000},
    '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000}};

  always #20 pclk = ~pclk;

  ptc_tick_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .low_power_osc_clock(src_clk[0]), .external_ref_clock(src_clk[1]),
    .internal_ref_clock(src_clk[2]), .tick_irq);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Releases psel for a cycle, so calls never re-drive in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Levels held 2 pclk: sync needs two; keeps long runs short
  task edges(input int k, input int n);
    repeat (n)
    begin
      src_clk[k] <= 1'b1;
      repeat (2) @(posedge pclk);
      src_clk[k] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask : edges

  task run(input int n);
    apb(1'b1, PTC_CTRL_OFFSET, {24'h0, 1'b1, s[1:0], 1'b1, p[3:0]});
    apb(1'b1, PTC_COMPARE_OFFSET, c);
    cnt = 0;
    flag = 0;
    cmpv = c;
    edges(s[1] ? 2 : s[0], n);
    repeat (n / r)
      if (cnt == cmpv)
      begin
        cnt = 0;
        flag = 1;
      end
      else
        cnt++;
    apb(1'b0, PTC_COUNT_OFFSET, 0);
    chk("count", rd, cnt);
    apb(1'b1, PTC_CTRL_OFFSET, {24'h0, 1'b0, s[1:0], 1'b1, p[3:0]});
    apb(1'b0, PTC_CTRL_OFFSET, 0);
    chk("ctrl", rd, {24'h0, flag[0], s[1:0], 1'b1, p[3:0]});
    chk("irq", {31'h0, tick_irq}, flag);
    apb(1'b1, PTC_CTRL_OFFSET, {24'h0, 1'b1, s[1:0] ^ 2'b10, 1'b0, 4'h0});
    // Edges on the newly selected source: prescaler off must ignore them
    edges(s[1] ? s[0] : 2, 3);
    apb(1'b0, PTC_COUNT_OFFSET, 0);
    chk("restart", rd, 0);
    chk("irq clear", {31'h0, tick_irq}, 0);
    apb(1'b0, PTC_CTRL_OFFSET, 0);
    chk("flag clear", rd, {24'h0, 1'b0, s[1:0] ^ 2'b10, 1'b0, 4'h0});
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hB3EAA63F));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 12; a += 4)
    begin
      apb(1'b0, a[11:0], 0);
      chk("reset value", rd, 0);
    end
    apb(1'b0, 12'h00C, 0);
    chk("unmapped err", {31'h0, err}, 1);
    chk("unmapped read", rd, 0);
    v = $urandom;
    apb(1'b1, PTC_COMPARE_OFFSET, v);
    apb(1'b1, PTC_COUNT_OFFSET, 32'hFF);
    apb(1'b0, PTC_COMPARE_OFFSET, 0);
    chk("compare", rd, {24'h0, v[7:0]});
    apb(1'b0, PTC_COUNT_OFFSET, 0);
    chk("count write", rd, 0);
    // Lane 0 strobe low: the write must be dropped
    pstrb <= 4'h0;
    apb(1'b1, PTC_COMPARE_OFFSET, ~v);
    pstrb <= 4'hF;
    apb(1'b0, PTC_COMPARE_OFFSET, 0);
    chk("masked write", rd, {24'h0, v[7:0]});
    // Divide by one from the low-power source, then rewrite the same compare
    apb(1'b1, PTC_CTRL_OFFSET, 32'h00000008);
    apb(1'b1, PTC_COMPARE_OFFSET, 32'h000000FF);
    edges(0, 5);
    apb(1'b0, PTC_COUNT_OFFSET, 0);
    chk("count before", rd, 5);
    apb(1'b1, PTC_COMPARE_OFFSET, 32'h000000FF);
    apb(1'b0, PTC_COUNT_OFFSET, 0);
    chk("compare restart", rd, 0);
    // Slow ratios only on bit0 sources: run length trade-off
    for (int i = 0; i < 8; i++)
    begin
      s = i % 4;
      p = s[0] ? 8 : (i == 4 ? 1 : $urandom_range(8, 13));
      c = i < 2 ? 0 : (s[0] ? $urandom_range(0, 1) : $urandom_range(0, 5));
      r = div[s % 2][p];
      run(r * (c + 1) + $urandom_range(0, r));
    end
    give_verdict;
  end

  initial
  begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    give_verdict;
  end
endmodule : tb_ptc_tick_counter

bind ptc_tick_counter ptc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .prdata, .pslverr, .tick_irq);

`default_nettype wire
